// *** logic/asc_audio_serial.sv ***
// Audio serial interface: configuration, data registers, mu-law unit and serial engine.
// Behaviour
// - Disabled plus compress: squeeze written 16-bit word.
// - Enabled plus compress: squeeze each received sample.
// - Transmit mono repeats sample in both channels.
// - Receive mono drops right-channel samples.
// - Master bit selects generated or pin clocks.
// - Disabled link keeps mu-law unit usable.
// - Word-size field is sample length minus one.
// - Master word select toggles after each sample.
// - Trigger field selects word-counter copy source.
// - Location bit picks first or second pins.
// - Enabled link owns its pins.
// - Two high writes clear transmit low byte.
// - Deep-sleep wake resets the low data byte.
// - Saturating word counter copied and cleared.
// - High byte access clears receive/transmit flags.
`include "asc_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module asc_audio_serial
	import asc_pkg::*;
(
	input wire logic clock, // System clock, 100 MHz.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic [15:0] regAddr, // Data-space byte address.
	input wire logic regWrite, // One-cycle write strobe.
	input wire logic regRead, // One-cycle read strobe.
	input wire logic [7:0] regWdata, // Write data.
	output logic [7:0] regRdata, // Read data, valid the cycle after regRead.
	input wire logic wakeFromDeepSleep, // Pulse on return from sleep level two or three.
	input wire logic usbFrameStart, // Start-of-frame pulse.
	input wire logic pinEdgeTrigger, // Pin transition pulse.
	input wire logic timerOneCompareZero, // Timer compare pulse.
	input wire logic serialClockIn, // Bit clock from the pin.
	input wire logic wordSelectIn, // Word select from the pin.
	input wire logic serialDataIn, // Receive data from the pin.
	output logic serialClockOut, // Generated bit clock.
	output logic serialClockOe, // Bit clock driven.
	output logic wordSelectOut, // Generated word select.
	output logic wordSelectOe, // Word select driven.
	output logic serialDataOut, // Transmit data.
	output logic serialDataOe, // Transmit data driven.
	output logic pinLocationSel, // 0 first pin set, 1 second pin set.
	output logic pinsOwned, // Link takes its pins over other users.
	output logic txReady, // Transmit FIFO can take a sample.
	output logic txPendingFlag, // Transmit buffer wants data.
	output logic rxPendingFlag // Receive buffer holds data.
);

	localparam asc_state_type RESET_STATE = '{
		cfg0: `ASC_CFG0_RESET,
		cfg1: `ASC_CFG1_RESET,
		datLow: `ASC_DATA_RESET,
		datHigh: `ASC_DATA_RESET,
		clkDiv0: `ASC_CLKDIV0_RESET,
		clkDiv1: `ASC_CLKDIV1_RESET,
		clkDiv2: `ASC_CLKDIV2_RESET,
		default: '0
	};
	localparam logic [7:0] HALF_LAST = 8'(`ASC_SCLK_HALF_CYCLES - 1);

	asc_state_type st;
	asc_state_type next_st;
	logic enabled;
	logic master;
	logic doCompress;
	logic doExpand;
	logic hiWrite;
	logic loWrite;
	logic hiRead;
	logic divTick;
	logic riseEv;
	logic fallEv;
	logic wsNow;
	logic trigHit;
	logic [4:0] wordSize;
	logic [15:0] txWord;
	logic [15:0] rxWord;
	logic fifoPush;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoPop;
	logic [15:0] fifoOutData;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [7:0] ulawCompress(input logic [15:0] sample);
		logic sign;
		logic [15:0] mag;
		logic [2:0] expo;
		logic [3:0] mant;
		sign = sample[15];
		mag = sign ? 16'(~sample + 16'h0001) : sample;
		if (mag > `ASC_ULAW_CLIP) begin
			mag = `ASC_ULAW_CLIP;
		end
		mag = 16'(mag + `ASC_ULAW_BIAS);
		expo = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (mag[i + 7]) begin
				expo = 3'(i);
			end
		end
		mant = 4'(mag >> ({1'b0, expo} + 4'h3));
		return ~{sign, expo, mant};
	endfunction

	function automatic logic [15:0] ulawExpand(input logic [7:0] code);
		logic [7:0] inv;
		logic [15:0] mag;
		inv = ~code;
		mag = 16'(({9'h000, inv[3:0], 3'h0} + `ASC_ULAW_BIAS) << inv[6:4]);
		return inv[7] ? 16'(`ASC_ULAW_BIAS - mag) : 16'(mag - `ASC_ULAW_BIAS);
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	assign enabled = st.cfg0[`ASC_CFG0_ENABLE_BIT];
	assign master = st.cfg0[`ASC_CFG0_MASTER_BIT];
	assign doCompress = st.cfg0[`ASC_CFG0_COMPRESS_BIT];
	assign doExpand = st.cfg0[`ASC_CFG0_EXPAND_BIT];
	assign wordSize = st.cfg1[`ASC_CFG1_WORDS_MSB:`ASC_CFG1_WORDS_LSB];
	assign hiWrite = regWrite && regAddr == `ASC_ADDR_DATA_HIGH;
	assign loWrite = regWrite && regAddr == `ASC_ADDR_DATA_LOW;
	assign hiRead = regRead && regAddr == `ASC_ADDR_DATA_HIGH;

	// Master mode runs the bit clock from a divider; slave mode finds edges of the synced pin.
	assign divTick = st.divCount == HALF_LAST;
	assign riseEv = enabled && (master ? (divTick && !st.genSclk) :
		(st.sclkSync && !st.sclkPrev));
	assign fallEv = enabled && (master ? (divTick && st.genSclk) :
		(!st.sclkSync && st.sclkPrev));
	assign wsNow = master ? st.genWs : st.wsSync;

	always_comb begin
		case (asc_trigger_type'(st.cfg1[`ASC_CFG1_TRIG_MSB:`ASC_CFG1_TRIG_LSB]))
			ASC_TRIG_USB_FRAME: trigHit = usbFrameStart;
			ASC_TRIG_PIN_EDGE: trigHit = pinEdgeTrigger;
			ASC_TRIG_TIMER: trigHit = timerOneCompareZero;
			default: trigHit = 1'b0;
		endcase
	end

	// A high write with no low write since the last one sends a zero low byte.
	assign txWord = doExpand ? ulawExpand(regWdata) :
		{regWdata, st.lowSinceHigh ? st.datLow : 8'h00};
	assign fifoPush = hiWrite && enabled;
	assign rxWord = {st.rxShift[14:0], st.sdSync};

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_st = st;
		next_st.sclkMeta = serialClockIn;
		next_st.sclkSync = st.sclkMeta;
		next_st.sclkPrev = st.sclkSync;
		next_st.wsMeta = wordSelectIn;
		next_st.wsSync = st.wsMeta;
		next_st.sdMeta = serialDataIn;
		next_st.sdSync = st.sdMeta;
		fifoPop = 1'b0;

		// Register reads; data is registered and valid in the cycle after the strobe.
		if (regRead) begin
			case (regAddr)
				`ASC_ADDR_CFG0: next_st.rdData = st.cfg0;
				`ASC_ADDR_CFG1: next_st.rdData = st.cfg1;
				`ASC_ADDR_DATA_LOW: next_st.rdData = st.datLow;
				`ASC_ADDR_DATA_HIGH: next_st.rdData = st.datHigh;
				`ASC_ADDR_WORD_COUNT: next_st.rdData = st.wcntLow;
				`ASC_ADDR_STATUS: next_st.rdData = {st.txUnderflow, st.rxOverflow, st.txRight,
					st.rxRight, st.txPending, st.rxPending, st.wcntHigh};
				`ASC_ADDR_CLKDIV0: next_st.rdData = st.clkDiv0;
				`ASC_ADDR_CLKDIV1: next_st.rdData = st.clkDiv1;
				`ASC_ADDR_CLKDIV2: next_st.rdData = st.clkDiv2;
				default: next_st.rdData = 8'h00;
			endcase
		end
		if (hiRead) begin
			next_st.rxPending = 1'b0;
		end

		// Register writes.
		if (regWrite) begin
			case (regAddr)
				`ASC_ADDR_CFG0: next_st.cfg0 = regWdata;
				`ASC_ADDR_CFG1: next_st.cfg1 = regWdata;
				`ASC_ADDR_CLKDIV0: next_st.clkDiv0 = regWdata;
				`ASC_ADDR_CLKDIV1: next_st.clkDiv1 = regWdata;
				`ASC_ADDR_CLKDIV2: next_st.clkDiv2 = regWdata;
				`ASC_ADDR_STATUS: begin
					next_st.txUnderflow = regWdata[`ASC_STAT_TX_UNDERFLOW_BIT];
					next_st.rxOverflow = regWdata[`ASC_STAT_RX_OVERFLOW_BIT];
					next_st.txPending = st.txPending | regWdata[`ASC_STAT_TX_PENDING_BIT];
					next_st.rxPending = next_st.rxPending | regWdata[`ASC_STAT_RX_PENDING_BIT];
				end
				default: ;
			endcase
		end
		if (loWrite) begin
			next_st.datLow = regWdata;
			next_st.lowSinceHigh = 1'b1;
		end
		if (hiWrite) begin
			next_st.lowSinceHigh = 1'b0;
			next_st.txPending = 1'b0;
			next_st.datHigh = regWdata;
			// The stand-alone unit settles in one cycle; software keeps only one option set.
			if (!enabled && doExpand && !doCompress) begin
				{next_st.datHigh, next_st.datLow} = ulawExpand(regWdata);
			end else if (!enabled && doCompress && !doExpand) begin
				next_st.datHigh = ulawCompress({regWdata, st.datLow});
			end
			if (enabled && !st.cfg0[`ASC_CFG0_TX_MONO_BIT]) begin
				next_st.txRight = !st.txRight;
			end else begin
				next_st.txRight = 1'b0;
			end
		end

		// Word counter: a copy triggered in the same cycle as a word-select change keeps that
		// change, so no transition is lost between two readings.
		if (trigHit || (regWrite && regAddr == `ASC_ADDR_WORD_COUNT)) begin
			next_st.wcntLow = st.wordCounter[7:0];
			next_st.wcntHigh = st.wordCounter[9:8];
			next_st.wordCounter = 10'h000;
		end

		// Master clock and word-select generation.
		if (enabled && master) begin
			next_st.divCount = divTick ? 8'h00 : 8'(st.divCount + 8'h01);
			if (divTick) begin
				next_st.genSclk = !st.genSclk;
				if (st.genSclk) begin
					if (st.bitCount == wordSize) begin
						next_st.genWs = !st.genWs;
						next_st.bitCount = 5'h00;
					end else begin
						next_st.bitCount = 5'(st.bitCount + 5'h01);
					end
				end
			end
		end else begin
			next_st.divCount = 8'h00;
			next_st.genSclk = 1'b0;
			next_st.genWs = 1'b0;
			next_st.bitCount = 5'h00;
		end

		// Word select is tracked while off, so enabling never sees a stale level change.
		if (!enabled) begin
			next_st.wsPrev = wsNow;
		end

		// Serial engine: sample on rising bit-clock edges, shift out on falling ones.
		if (riseEv) begin
			next_st.rxShift = rxWord;
			next_st.wsPrev = wsNow;
			if (wsNow != st.wsPrev) begin
				if (next_st.wordCounter != `ASC_WORD_COUNT_MAX) begin
					next_st.wordCounter = 10'(next_st.wordCounter + 10'h001);
				end
				// The bit taken at a word-select change closes the previous channel.
				if (!(st.cfg0[`ASC_CFG0_RX_MONO_BIT] && st.wsPrev)) begin
					if (doCompress) begin
						next_st.datHigh = ulawCompress(rxWord);
					end else begin
						{next_st.datHigh, next_st.datLow} = rxWord;
					end
					next_st.rxOverflow = next_st.rxOverflow | next_st.rxPending;
					next_st.rxPending = 1'b1;
					next_st.rxRight = st.wsPrev;
				end
				if (!wsNow || !st.cfg0[`ASC_CFG0_TX_MONO_BIT]) begin
					if (fifoOutValid) begin
						fifoPop = 1'b1;
						next_st.txShift = fifoOutData;
						next_st.txHeld = fifoOutData;
						next_st.txPending = 1'b1;
					end else begin
						next_st.txShift = 16'h0000;
						next_st.txHeld = 16'h0000;
						next_st.txUnderflow = 1'b1;
					end
				end else begin
					next_st.txShift = st.txHeld;
				end
			end
		end
		if (fallEv) begin
			next_st.sdOut = st.txShift[15];
			next_st.txShift = {st.txShift[14:0], 1'b0};
		end

		// Returning from the deepest sleep levels leaves both data bytes at reset.
		if (wakeFromDeepSleep) begin
			next_st.datLow = `ASC_DATA_RESET;
			next_st.datHigh = `ASC_DATA_RESET;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st <= RESET_STATE;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Samples written while the FIFO is full are dropped; software watches txReady.
	asc_sample_fifo #(
		.WIDTH(16),
		.DEPTH(`ASC_FIFO_DEPTH)
	) txFifo (
		.clock(clock),
		.rst_b(rst_b),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData(txWord),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData)
	);

	assign regRdata = st.rdData;
	assign txReady = fifoInReady;
	assign serialClockOut = st.genSclk;
	assign serialClockOe = enabled && master;
	assign wordSelectOut = st.genWs;
	assign wordSelectOe = enabled && master;
	assign serialDataOut = st.sdOut;
	assign serialDataOe = enabled;
	assign pinLocationSel = st.cfg1[`ASC_CFG1_LOC_BIT];
	assign pinsOwned = enabled;
	assign txPendingFlag = st.txPending;
	assign rxPendingFlag = st.rxPending;

endmodule
`default_nettype wire

// *** logic/asc_pkg.sv ***
// Types shared by the audio serial block.
package asc_pkg;

	typedef enum logic [1:0] {
		ASC_TRIG_NONE = 2'h0,
		ASC_TRIG_USB_FRAME = 2'h1,
		ASC_TRIG_PIN_EDGE = 2'h2,
		ASC_TRIG_TIMER = 2'h3
	} asc_trigger_type;

	typedef struct packed {
		logic [7:0] cfg0, cfg1, datLow, datHigh, wcntLow, clkDiv0, clkDiv1, clkDiv2, rdData;
		logic [1:0] wcntHigh;
		logic txUnderflow, rxOverflow, txRight, rxRight, txPending, rxPending, lowSinceHigh;
		logic [9:0] wordCounter;
		logic sclkMeta, sclkSync, sclkPrev, wsMeta, wsSync, wsPrev, sdMeta, sdSync;
		logic [7:0] divCount;
		logic genSclk, genWs;
		logic [4:0] bitCount;
		logic [15:0] txShift, rxShift, txHeld;
		logic sdOut;
	} asc_state_type;

endpackage

// *** logic/asc_regs_map.svh ***
// Register offsets, field positions, reset values and timing counts of the audio serial block.
`ifndef ASC_REGS_MAP_SVH
`define ASC_REGS_MAP_SVH

`define ASC_ADDR_CFG0 16'hDF40
`define ASC_ADDR_CFG1 16'hDF41
`define ASC_ADDR_DATA_LOW 16'hDF42
`define ASC_ADDR_DATA_HIGH 16'hDF43
`define ASC_ADDR_WORD_COUNT 16'hDF44
`define ASC_ADDR_STATUS 16'hDF45
`define ASC_ADDR_CLKDIV0 16'hDF46
`define ASC_ADDR_CLKDIV1 16'hDF47
`define ASC_ADDR_CLKDIV2 16'hDF48

`define ASC_CFG0_EXPAND_BIT 5
`define ASC_CFG0_COMPRESS_BIT 4
`define ASC_CFG0_TX_MONO_BIT 3
`define ASC_CFG0_RX_MONO_BIT 2
`define ASC_CFG0_MASTER_BIT 1
`define ASC_CFG0_ENABLE_BIT 0
`define ASC_CFG1_WORDS_MSB 7
`define ASC_CFG1_WORDS_LSB 3
`define ASC_CFG1_TRIG_MSB 2
`define ASC_CFG1_TRIG_LSB 1
`define ASC_CFG1_LOC_BIT 0
`define ASC_STAT_TX_UNDERFLOW_BIT 7
`define ASC_STAT_RX_OVERFLOW_BIT 6
`define ASC_STAT_TX_PENDING_BIT 3
`define ASC_STAT_RX_PENDING_BIT 2

`define ASC_CFG0_RESET 8'h00
`define ASC_CFG1_RESET 8'h78
`define ASC_DATA_RESET 8'h00
`define ASC_CLKDIV0_RESET 8'h93
`define ASC_CLKDIV1_RESET 8'hE2
`define ASC_CLKDIV2_RESET 8'h04

`define ASC_ULAW_BIAS 16'h0084
`define ASC_ULAW_CLIP 16'h7F7B
`define ASC_WORD_COUNT_MAX 10'h3FF
`define ASC_FIFO_DEPTH 16

`define ASC_CLOCK_PERIOD_NS 10
`define ASC_SCLK_HALF_NS 40
`define ASC_SCLK_HALF_CYCLES (`ASC_SCLK_HALF_NS / `ASC_CLOCK_PERIOD_NS)

`endif

// *** logic/asc_sample_fifo.sv ***
// Sample FIFO with valid and ready on both sides and a registered head word.
`timescale 1ns/1ps
`default_nettype none

module asc_sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clock, // System clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic inValid, // Producer offers a word.
	output logic inReady, // Room for a word.
	input wire logic [WIDTH-1:0] inData, // Word offered.
	output logic outValid, // Head word present.
	input wire logic outReady, // Consumer takes the head word.
	output logic [WIDTH-1:0] outData // Head word.
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wrPtr, rdPtr;
		logic [AW:0] count;
		logic [WIDTH-1:0] head;
	} asc_fifo_state_type;

	asc_fifo_state_type st;
	asc_fifo_state_type next_st;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////////////

	assign inReady = st.count != (AW + 1)'(DEPTH);
	assign outValid = st.count != '0;
	assign outData = st.head;
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wrPtr] = inData;
			next_st.wrPtr = AW'(st.wrPtr + 1'b1);
		end
		if (pop) begin
			next_st.rdPtr = AW'(st.rdPtr + 1'b1);
		end
		next_st.count = (AW + 1)'(st.count + {AW'(0), push} - {AW'(0), pop});
		// The head is refreshed every cycle so a word pushed into an empty FIFO shows next cycle.
		next_st.head = next_st.mem[next_st.rdPtr];
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule
`default_nettype wire

// *** tb/asc_audio_serial_asserts.sv ***
// Port-level checks of the audio serial block.
`include "asc_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module asc_audio_serial_asserts (
	input wire logic clock, // System clock.
	input wire logic rst_b, // Reset, active low.
	input wire logic [15:0] regAddr, // Address.
	input wire logic regWrite, // Write strobe.
	input wire logic regRead, // Read strobe.
	input wire logic [7:0] regWdata, // Write data.
	input wire logic [7:0] regRdata, // Read data.
	input wire logic wakeFromDeepSleep, // Wake pulse.
	input wire logic serialClockOut, // Bit clock.
	input wire logic serialClockOe, // Bit clock driven.
	input wire logic wordSelectOut, // Word select.
	input wire logic wordSelectOe, // Word select driven.
	input wire logic serialDataOe, // Data driven.
	input wire logic pinLocationSel, // Pin set.
	input wire logic pinsOwned, // Pin ownership.
	input wire logic txPendingFlag, // Transmit flag.
	input wire logic rxPendingFlag // Receive flag.
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire logic wrCfg0 = regWrite && regAddr == `ASC_ADDR_CFG0;
	wire logic highAcc = regAddr == `ASC_ADDR_DATA_HIGH && !pinsOwned;
	sequence wakeThenRead;
		wakeFromDeepSleep ##1 (regRead && regAddr == `ASC_ADDR_DATA_LOW);
	endsequence
	sequence clockHeld;
		(!serialClockOe || $stable(serialClockOut)) [*3];
	endsequence
	a_enable_owns: assert property (wrCfg0 |=> pinsOwned == $past(regWdata[0]))
		else $error("Pin ownership does not follow enable.");
	a_master_drive: assert property (wrCfg0
		|=> serialClockOe == ($past(regWdata[0]) && $past(regWdata[1])))
		else $error("Clock drive does not follow master enable.");
	a_ws_pair: assert property (wordSelectOe == serialClockOe)
		else $error("Word select drive differs from clock drive.");
	a_data_drive: assert property (serialDataOe == pinsOwned)
		else $error("Data drive differs from enable.");
	a_loc_follows: assert property (regWrite && regAddr == `ASC_ADDR_CFG1
		|=> pinLocationSel == $past(regWdata[0]))
		else $error("Pin set does not follow location bit.");
	a_half_period: assert property (serialClockOe && $changed(serialClockOut)
		|=> clockHeld ##1 (!serialClockOe || $changed(serialClockOut)))
		else $error("Generated half period is not four cycles.");
	a_ws_on_low: assert property (serialClockOe && $changed(wordSelectOut) |-> !serialClockOut)
		else $error("Word select moved while bit clock high.");
	a_tx_clear: assert property (regWrite && highAcc |=> !txPendingFlag)
		else $error("High byte write left transmit flag set.");
	a_rx_clear: assert property (regRead && highAcc |=> !rxPendingFlag)
		else $error("High byte read left receive flag set.");
	a_wake_low: assert property (wakeThenRead |=> regRdata == `ASC_DATA_RESET)
		else $error("Low byte not at reset value after wake.");
endmodule

bind asc_audio_serial asc_audio_serial_asserts i_chk (.clock(clock), .rst_b(rst_b),
	.regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
	.regRdata(regRdata), .wakeFromDeepSleep(wakeFromDeepSleep),
	.serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
	.wordSelectOut(wordSelectOut), .wordSelectOe(wordSelectOe), .serialDataOe(serialDataOe),
	.pinLocationSel(pinLocationSel), .pinsOwned(pinsOwned),
	.txPendingFlag(txPendingFlag), .rxPendingFlag(rxPendingFlag));
`default_nettype wire

// *** tb/asc_codec_model.sv ***
// Behavioural codec on the far side of the serial link.
`timescale 1ns/1ps
`default_nettype none
module asc_codec_model (
	input wire logic run, // Codec runs its own clocks.
	input wire logic pinClk, // Resolved bit clock pin.
	input wire logic pinWs, // Resolved word select pin.
	input wire logic devSd, // Data from the block.
	input wire logic [15:0] leftWord, // Left sample sent.
	input wire logic [15:0] rightWord, // Right sample sent.
	output logic sclk, // Own bit clock.
	output logic ws, // Own word select.
	output logic sd, // Data to the block.
	output logic gotValid, // Toggles per captured word.
	output logic [15:0] gotWord // Captured word.
);
	logic [3:0] bitIdx = 4'h0;
	logic [15:0] shiftIn = 16'h0000;
	logic lastWs = 1'b0;
	initial begin
		sclk = 1'b0;
		ws = 1'b0;
		sd = 1'b0;
		gotValid = 1'b0;
		gotWord = 16'h0000;
	end
	// The clock stands still while run is low; idle data keeps moving so no stale bit is read.
	always #40 begin
		if (run) begin
			sclk = ~sclk;
			if (!sclk) begin
				sd = ws ? rightWord[4'hF - bitIdx] : leftWord[4'hF - bitIdx];
				if (bitIdx == 4'hF) ws = ~ws;
				bitIdx = bitIdx + 4'h1;
			end
		end else sd = ~sd;
	end
	always @(posedge pinClk) begin
		if (pinWs != lastWs) begin
			gotWord = {shiftIn[14:0], devSd};
			gotValid = ~gotValid;
		end
		shiftIn = {shiftIn[14:0], devSd};
		lastWs = pinWs;
	end
endmodule
`default_nettype wire

// *** tb/audio_serial_config_data_tb.sv ***
// Self-checking bench of the audio serial block against a codec model.
`include "asc_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module audio_serial_config_data_tb;
	logic clock = 1'b0;
	logic rst_b, regWrite, regRead, wake, run, prevGot, gotValid, codSclk, codWs, codSd;
	logic sclkOut, sclkOe, wsOut, wsOe, sdOut, sdOe, pinLoc, owned, txReady, txPend, rxPend;
	logic [15:0] regAddr, s, lw, gotWord;
	logic [7:0] regWdata, regRdata, v, v0, v2;
	logic [3:0] trig;
	int mismatches = 0;
	int checksDone = 0;
	logic [15:0] expQ [$];
	logic [7:0] rstVal [10] = '{8'h00, 8'h78, 8'h00, 8'h00, 8'h00, 8'h00, 8'h93, 8'hE2,
		8'h04, 8'h00};
	wire logic pinClk = sclkOe ? sclkOut : codSclk;
	wire logic pinWs = wsOe ? wsOut : codWs;

	asc_audio_serial i_dut (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
		.wakeFromDeepSleep(wake), .usbFrameStart(trig[1]), .pinEdgeTrigger(trig[2]),
		.timerOneCompareZero(trig[3]), .serialClockIn(pinClk), .wordSelectIn(pinWs),
		.serialDataIn(codSd), .serialClockOut(sclkOut), .serialClockOe(sclkOe),
		.wordSelectOut(wsOut), .wordSelectOe(wsOe), .serialDataOut(sdOut),
		.serialDataOe(sdOe), .pinLocationSel(pinLoc), .pinsOwned(owned), .txReady(txReady),
		.txPendingFlag(txPend), .rxPendingFlag(rxPend));
	asc_codec_model i_codec (.run(run), .pinClk(pinClk), .pinWs(pinWs), .devSd(sdOut),
		.leftWord(lw), .rightWord(~lw), .sclk(codSclk), .ws(codWs), .sd(codSd),
		.gotValid(gotValid), .gotWord(gotWord));

	initial forever #5 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] ulaw(input logic [15:0] x);
		logic [15:0] m;
		logic [2:0] e;
		m = x[15] ? -x : x;
		if (m > `ASC_ULAW_CLIP) m = `ASC_ULAW_CLIP;
		m = m + `ASC_ULAW_BIAS;
		e = 3'h0;
		for (int i = 8; i <= 14; i++) if (m[i]) e = 3'(i - 7);
		return ~{x[15], e, 4'(m >> (e + 3))};
	endfunction
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		checksDone++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		#1;
		regWrite <= 1'b0;
		@(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		#1;
		regRead <= 1'b0;
		d = regRdata;
		@(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		cmp(16'(d), 16'(e));
	endtask
	task automatic pulse(input logic [3:0] p);
		trig <= p;
		@(posedge clock);
		#1;
		trig <= 4'h0;
		@(posedge clock);
		#1;
	endtask
	// Waits are bounded so a stuck link ends the run instead of hanging it.
	task automatic waitUntil(input bit rx);
		int n;
		for (n = 0; n < 4000; n++) begin
			if (rx ? rxPend === 1'b1 : expQ.size() == 0) break;
			@(posedge clock);
			#1;
		end
		if (n == 4000) begin
			mismatches++;
			$display("Error at %0t: wait ran out", $time);
			final_report();
		end
	endtask

	// Idle zero words from an empty buffer are skipped; every sample sent is nonzero.
	always @(posedge clock) begin
		if (gotValid !== prevGot) begin
			prevGot <= gotValid;
			if (gotWord !== 16'h0000 && expQ.size() == 0) cmp(gotWord, 16'h0000);
			else if (gotWord !== 16'h0000) cmp(gotWord, expQ.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	initial begin
		regAddr = 16'h0000;
		regWdata = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		wake = 1'b0;
		trig = 4'h0;
		run = 1'b0;
		lw = 16'h0000;
		prevGot = 1'b0;
		rst_b = 1'b0;
		void'($urandom(32'h908D));
		repeat (8) @(posedge clock);
		#1;
		rst_b = 1'b1;
		for (int i = 0; i < 10; i++) chk(`ASC_ADDR_CFG0 + 16'(i), rstVal[i]);
		wr(`ASC_ADDR_CFG0, 8'h10);
		repeat (4) begin
			s = 16'($urandom);
			wr(`ASC_ADDR_STATUS, 8'h0C);
			wr(`ASC_ADDR_DATA_LOW, s[7:0]);
			wr(`ASC_ADDR_DATA_HIGH, s[15:8]);
			cmp(16'(txPend), 16'h0000);
			chk(`ASC_ADDR_DATA_HIGH, ulaw(s));
			cmp(16'(rxPend), 16'h0000);
		end
		// Expansion is checked by round trip; odd codes are skipped, as code 7F holds negative zero, which cannot return.
		wr(`ASC_ADDR_CFG0, 8'h20);
		repeat (4) begin
			v = 8'($urandom) & 8'hFE;
			wr(`ASC_ADDR_DATA_HIGH, v);
			rd(`ASC_ADDR_DATA_HIGH, v2);
			rd(`ASC_ADDR_DATA_LOW, v0);
			cmp(16'(ulaw({v2, v0})), 16'(v));
		end
		wr(`ASC_ADDR_CFG0, 8'h00);
		wr(`ASC_ADDR_DATA_LOW, 8'h5A);
		wake <= 1'b1;
		@(posedge clock);
		#1;
		wake <= 1'b0;
		chk(`ASC_ADDR_DATA_LOW, 8'h00);
		wr(`ASC_ADDR_CFG0, 8'h0B);
		cmp(16'({owned, sclkOe}), 16'h0003);
		s = 16'($urandom) | 16'h0101;
		wr(`ASC_ADDR_DATA_LOW, s[7:0]);
		wr(`ASC_ADDR_DATA_HIGH, s[15:8]);
		expQ.push_back(s);
		expQ.push_back(s);
		waitUntil(1'b0);
		wr(`ASC_ADDR_CFG0, 8'h03);
		for (int i = 0; i < 40 && txReady === 1'b1; i++) begin
			s = 16'($urandom) | 16'h0100;
			if (i % 3 != 0) wr(`ASC_ADDR_DATA_LOW, s[7:0]);
			else s[7:0] = 8'h00;
			wr(`ASC_ADDR_DATA_HIGH, s[15:8]);
			expQ.push_back(s);
		end
		cmp(16'(txReady), 16'h0000);
		waitUntil(1'b0);
		for (int t = 0; t < 4; t++) begin
			wr(`ASC_ADDR_CFG1, {5'h0F, 2'(t), 1'(t)});
			cmp(16'(pinLoc), 16'(t % 2));
			wr(`ASC_ADDR_WORD_COUNT, 8'h00);
			repeat (300) @(posedge clock);
			#1;
			rd(`ASC_ADDR_WORD_COUNT, v0);
			pulse(4'hE & ~(4'h1 << t));
			chk(`ASC_ADDR_WORD_COUNT, v0);
			pulse(4'h1 << t);
			rd(`ASC_ADDR_WORD_COUNT, v2);
			cmp(16'((t == 0) ? (v2 == v0) : (v2 >= 8'h02 && v2 <= 8'h03)), 16'h0001);
		end
		wr(`ASC_ADDR_CFG0, 8'h00);
		// Master-mode receives left the flag set; empty the buffer before the codec runs.
		rd(`ASC_ADDR_DATA_HIGH, v);
		cmp(16'(rxPend), 16'h0000);
		lw = 16'($urandom) | 16'h0001;
		wr(`ASC_ADDR_CFG0, 8'h05);
		cmp(16'({owned, sclkOe}), 16'h0002);
		run = 1'b1;
		repeat (3) begin
			waitUntil(1'b1);
			chk(`ASC_ADDR_DATA_LOW, lw[7:0]);
			chk(`ASC_ADDR_DATA_HIGH, lw[15:8]);
		end
		wr(`ASC_ADDR_CFG0, 8'h15);
		waitUntil(1'b1);
		rd(`ASC_ADDR_DATA_HIGH, v);
		waitUntil(1'b1);
		chk(`ASC_ADDR_DATA_HIGH, ulaw(lw));
		run = 1'b0;
		final_report();
	end
endmodule
`default_nettype wire
